// ==== hw/lsp_ctrl.sv ====
// Purpose: segment pin selection and lcd drive power control behind apb
// Assumes: 125 MHz ref_clk, standby_mode is a pin from the power manager
// Notes:   only the pin-function and power/activate fields live here
//          clearing activate gates segment drive, supply and run only; port_enable keeps following the map and pin and display registers keep their values
//          pin map changes reach the pads one cycle after the write edge
//
// The register offsets and the APB register port were chosen for this implementation.
`include "lsp_defines.svh"

module lsp_ctrl
    import lsp_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    // apb slave
    input  lsp_pkg::lsp_apb_req_s   apb_req,
    output lsp_pkg::lsp_apb_rsp_s   apb_rsp,
    // chip power state, asynchronous
    input  wire logic               standby_mode,
    // to pads and analog
    output lsp_pkg::lsp_pins_t      seg_drive_en,
    output lsp_pkg::lsp_pins_t      port_enable,
    output logic                    lcd_supply_on,
    output logic                    lcd_run
);
    import lsp_pkg::*;

    // register state
    logic [7:0]  pin_ctrl_reg;
    logic [7:0]  pin_ctrl_next;
    logic [7:0]  disp_ctrl_reg;
    logic [7:0]  disp_ctrl_next;
    // standby synchroniser and its filtered level
    logic [2:0]  stby_sync_reg;
    logic [2:0]  stby_sync_next;
    logic        stby_reg;
    logic        stby_next;
    // pin map and power outputs
    lsp_pins_t   seg_map;
    lsp_pins_t   seg_drive_reg;
    lsp_pins_t   seg_drive_next;
    logic        supply_reg;
    logic        supply_next;
    logic        run_reg;
    logic        run_next;
    // read path
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        rerr_reg;
    logic        rerr_next;
    logic [31:0] status_word;

    // one aligned word per register; all twelve address bits take part
    function automatic logic addr_hit(input logic [11:0] addr,
                                      input logic [11:0] offset);
        return addr == offset;
    endfunction : addr_hit

    // registers are one byte wide; the rest of the bus word reads zero
    function automatic logic [31:0] byte_word(input logic [7:0] value);
        return {24'h00_0000, value};
    endfunction : byte_word

    // halted pins go quiet together; the port side keeps following the map
    function automatic lsp_pins_t gate_pins(input lsp_pins_t pins,
                                            input logic      enable);
        return pins & {`LSP_NUM_PINS{enable}};
    endfunction : gate_pins

    // bus phase decode
    wire         setup_phase = apb_req.psel & ~apb_req.penable;
    wire         access      = apb_req.psel & apb_req.penable;
    wire         wr_en       = access & apb_req.pwrite;
    wire         hit_pin     = addr_hit(apb_req.paddr, `LSP_OFF_PIN_CTRL);
    wire         hit_disp    = addr_hit(apb_req.paddr, `LSP_OFF_DISP_CTRL);
    wire         hit_stat    = addr_hit(apb_req.paddr, `LSP_OFF_STATUS);
    wire         addr_ok     = hit_pin | hit_disp | hit_stat;
    wire         wr_pin      = wr_en & hit_pin;
    wire         wr_disp     = wr_en & hit_disp;
    // fields in use
    wire [3:0]   seg_select  = pin_ctrl_reg[`LSP_SGS_MSB:`LSP_SGS_LSB];
    wire         act_bit     = disp_ctrl_reg[`LSP_DISP_ACT_BIT];
    wire         pwr_bit     = disp_ctrl_reg[`LSP_DISP_PWR_BIT];
    wire         stby_agree  = stby_sync_reg[1] == stby_sync_reg[2];
    // fields of the write word
    wire [3:0]   sgs_wr      = apb_req.pwdata[`LSP_SGS_MSB:`LSP_SGS_LSB];
    wire [2:0]   pin_hi_wr   = apb_req.pwdata[`LSP_PIN_HI_MSB:`LSP_PIN_HI_LSB];
    wire         pwr_wr      = apb_req.pwdata[`LSP_DISP_PWR_BIT];
    wire         act_wr      = apb_req.pwdata[`LSP_DISP_ACT_BIT];
    wire [4:0]   disp_lo_wr  = apb_req.pwdata[`LSP_DISP_LO_MSB:0];

    // pin bit 4 only ever holds zero and display bit 7 only ever one
    assign pin_ctrl_next  = wr_pin ? {pin_hi_wr, 1'b0, sgs_wr}
                                   : pin_ctrl_reg;
    assign disp_ctrl_next = wr_disp ? {1'b1, pwr_wr, act_wr, disp_lo_wr}
                                    : disp_ctrl_reg;

    lsp_seg_decode u_dec (
        .seg_select (seg_select),
        .seg_enable (seg_map)
    );

    // activate low only gates the segment drive, supply and run outputs, so a halt loses no setting
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_ctrl_reg <= `LSP_PIN_CTRL_RESET;
        end else begin
            pin_ctrl_reg <= pin_ctrl_next;
        end
    end

    // bit 7 leaves reset at one and no write can clear it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            disp_ctrl_reg <= `LSP_DISP_CTRL_RESET;
        end else begin
            disp_ctrl_reg <= disp_ctrl_next;
        end
    end

    // standby comes from another domain: three stages, a change counts once two agree
    assign stby_sync_next = {stby_sync_reg[1:0], standby_mode};
    assign stby_next      = stby_agree ? stby_sync_reg[2] : stby_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stby_sync_reg <= 3'h0;
        end else begin
            stby_sync_reg <= stby_sync_next;
        end
    end

    // holds the last agreed level while the two stages disagree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stby_reg <= 1'b0;
        end else begin
            stby_reg <= stby_next;
        end
    end

    // all pins re-map on one edge from a registered map, so untouched groups never glitch
    assign seg_drive_next = seg_map;
    assign supply_next    = pwr_bit & act_bit & ~stby_reg;
    assign run_next       = act_bit;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seg_drive_reg <= '0;
        end else begin
            seg_drive_reg <= seg_drive_next;
        end
    end

    // supply follows power enable only while active and awake
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_reg <= 1'b0;
        end else begin
            supply_reg <= supply_next;
        end
    end

    // run trails the activate bit by one cycle, like the supply
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
        end
    end

    assign seg_drive_en  = gate_pins(seg_drive_reg, run_reg);
    assign port_enable   = ~seg_drive_reg;
    assign lcd_supply_on = supply_reg;
    assign lcd_run       = run_reg;

    // read data is taken in the setup cycle and stands through the access cycle
    wire [31:0]  pin_word    = byte_word(pin_ctrl_reg);
    wire [31:0]  disp_word   = byte_word(disp_ctrl_reg);
    assign status_word = {29'h0000_0000, stby_reg, run_reg, supply_reg};
    assign rdata_next  = hit_pin  ? pin_word
                       : hit_disp ? disp_word
                       : hit_stat ? status_word
                       : 32'h0000_0000;
    // unmapped offsets answer with an error and read as zero
    assign rerr_next   = ~addr_ok;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (setup_phase) begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rerr_reg <= 1'b0;
        end else if (setup_phase) begin
            rerr_reg <= rerr_next;
        end
    end

    // no wait states: every access completes in its first cycle
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.prdata  = rdata_reg;
    // the error shows only while the access phase stands
    assign apb_rsp.pslverr = access & rerr_reg;

endmodule : lsp_ctrl

// ==== hw/lsp_defines.svh ====
// Purpose: offsets, field positions and reset values of the lcd pin and power block
// Assumes: apb with 32-bit data, one register per aligned word
// Notes:   included by the design modules lsp_ctrl and lsp_seg_decode; the package does not include it
`ifndef LSP_DEFINES_SVH
`define LSP_DEFINES_SVH

`define LSP_OFF_PIN_CTRL      12'h000
`define LSP_OFF_DISP_CTRL     12'h004
`define LSP_OFF_STATUS        12'h008

`define LSP_SGS_LSB           0
`define LSP_SGS_MSB           3
`define LSP_PIN_RSVD_BIT      4
`define LSP_PIN_HI_LSB        5
`define LSP_PIN_HI_MSB        7

`define LSP_DISP_RSVD_BIT     7
`define LSP_DISP_PWR_BIT      6
`define LSP_DISP_ACT_BIT      5
`define LSP_DISP_LO_MSB       4

`define LSP_PIN_CTRL_RESET    8'h00
`define LSP_DISP_CTRL_RESET   8'h80

`define LSP_NUM_PINS          25
`define LSP_GROUP_SIZE        4
`define LSP_NUM_GROUPS        6

`endif

// ==== hw/lsp_pkg.sv ====
// Purpose: types shared by the lcd pin and power block
// Assumes: widths are written out here to match lsp_defines.svh, which is not included
// Notes:   apb request travels as one struct
package lsp_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lsp_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } lsp_apb_rsp_s;

    typedef logic [24:0] lsp_pins_t;

endpackage : lsp_pkg

// ==== hw/lsp_seg_decode.sv ====
// Purpose: turn the four-bit segment select into a per-pin segment enable
// Assumes: pin 0 is the lowest segment pin, pin 24 the top single pin
// Notes:   pure decode; the caller registers the result
`include "lsp_defines.svh"

module lsp_seg_decode
    import lsp_pkg::*;
(
    // select
    input  wire logic [3:0] seg_select,
    // result
    output lsp_pkg::lsp_pins_t seg_enable
);

    logic [2:0] grp_cnt;
    logic       up_mode;
    logic       top_seg;
    logic [5:0] grp_seg;

    // upper bit clear: groups turn on from the bottom; set: they return to ports
    assign up_mode = ~seg_select[3];
    assign grp_cnt = seg_select[2:0];
    assign top_seg = up_mode ? (grp_cnt == 3'h7) : (grp_cnt != 3'h7);

    genvar g;
    generate
        for (g = 0; g < `LSP_NUM_GROUPS; g++) begin : g_grp
            assign grp_seg[g] = up_mode ? (grp_cnt > 3'(g))
                                        : (grp_cnt <= 3'(g)) && (grp_cnt != 3'h7);
            assign seg_enable[g*`LSP_GROUP_SIZE +: `LSP_GROUP_SIZE] = {4{grp_seg[g]}};
        end
    endgenerate

    assign seg_enable[`LSP_NUM_PINS-1] = top_seg;

endmodule : lsp_seg_decode

// ==== tb/lsp_ctrl_props.sv ====
// Purpose: port checks for lsp_ctrl
// Assumes: zero wait state apb
// Notes:   bound from the bench top
module lsp_ctrl_props
    import lsp_pkg::*;
(
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          rst_n,
    // bus and pins
    input lsp_pkg::lsp_apb_req_s apb_req,
    input lsp_pkg::lsp_apb_rsp_s apb_rsp,
    input wire logic          standby_mode,
    input lsp_pkg::lsp_pins_t seg_drive_en,
    input lsp_pkg::lsp_pins_t port_enable,
    input wire logic          lcd_supply_on,
    input wire logic          lcd_run
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic acc = apb_req.psel && apb_req.penable;
    wire logic wr0 = acc && apb_req.pwrite && apb_req.paddr == 12'h000;
    wire logic wr4 = acc && apb_req.pwrite && apb_req.paddr == 12'h004;
    a_no_overlap: assert property ((seg_drive_en & port_enable) == '0)
        else $error("pin both segment and port");
    a_supply_run: assert property (lcd_supply_on |-> lcd_run)
        else $error("supply on while halted");
    a_standby_cut: assert property (standby_mode [*6] |-> !lcd_supply_on)
        else $error("supply on in standby");
    a_halt_idle: assert property (!lcd_run |-> seg_drive_en == '0)
        else $error("segments driven while halted");
    a_run_write: assert property (wr4 |=> ##1 lcd_run == $past(apb_req.pwdata[5], 2))
        else $error("run flag missed write");
    a_power_off: assert property (wr4 && !apb_req.pwdata[6] |=> ##1 !lcd_supply_on)
        else $error("supply on after power cleared");
    a_map_hold: assert property (!$stable(port_enable) |-> $past(wr0, 2))
        else $error("pin map moved without write");
    a_rsvd_one: assert property (acc && !apb_req.pwrite && apb_req.paddr == 12'h004
        |-> apb_rsp.prdata[7])
        else $error("reserved bit read zero");
    cover property (wr0);
    cover property (lcd_supply_on);
    cover property (standby_mode && lcd_run);
endmodule : lsp_ctrl_props

// ==== tb/lsp_panel_model.sv ====
// Purpose: lcd panel seen from the segment pins
// Assumes: a segment lights only while drive supply is on
// Notes:   port pins never light the glass
module lsp_panel_model
    import lsp_pkg::*;
(
    // from the block
    input lsp_pkg::lsp_pins_t seg_drive_en,
    input wire logic          lcd_supply_on,
    // lit segments
    output lsp_pkg::lsp_pins_t lit
);
    timeunit 1ns;
    timeprecision 1ps;
    assign lit = lcd_supply_on ? seg_drive_en : '0;
endmodule : lsp_panel_model

// ==== tb/lcd_segment_pin_and_power_control_tb.sv ====
// Purpose: self-checking bench for lsp_ctrl
// Assumes: pready answers the access phase
// Notes:   outputs settle one cycle after the write edge
module lcd_segment_pin_and_power_control_tb
    import lsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst_n = 0, standby_mode = 0, sup, run;
    lsp_apb_req_s req = '0;
    lsp_apb_rsp_s rsp;
    lsp_pins_t    seg, prt, lit;
    logic [31:0]  q;
    logic         perr;
    int miscompares = 0, check_count = 0, cyc = 0;
    initial forever #4 ref_clk = ~ref_clk;
    lsp_ctrl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
        .standby_mode(standby_mode), .seg_drive_en(seg), .port_enable(prt),
        .lcd_supply_on(sup), .lcd_run(run));
    lsp_panel_model u_panel (.seg_drive_en(seg), .lcd_supply_on(sup), .lit(lit));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do @(posedge ref_clk); while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        perr = rsp.pslverr;
        req <= '0;
        repeat (2) @(negedge ref_clk);
    endtask : xfer
    function automatic lsp_pins_t exp_map(input logic [3:0] c);
        lsp_pins_t m;
        for (int g = 0; g < 6; g++) m[4*g+:4] = {4{c[3] ? g >= c[2:0] : g < c[2:0]}};
        m[24] = c[3] ? c != 4'hF : c == 4'h7;
        return m;
    endfunction : exp_map
    task automatic t_reset;
        chk(32'(prt), 32'h01FFFFFF);
        xfer(1'b0, 12'h000, 32'h0);
        chk(q, 32'h00);
        xfer(1'b0, 12'h004, 32'h0);
        chk(q, 32'h80);
        chk(32'(perr), 32'h0);
    endtask : t_reset
    task automatic t_codes;
        xfer(1'b1, 12'h004, 32'h60);
        for (int c = 0; c < 16; c++) begin
            xfer(1'b1, 12'h000, 32'(c));
            chk(32'(seg), 32'(exp_map(4'(c))));
            chk(32'(prt), {7'h00, ~exp_map(4'(c))});
            chk(32'(lit), 32'(exp_map(4'(c))));
        end
    endtask : t_codes
    task automatic t_power;
        xfer(1'b1, 12'h004, 32'h00);
        xfer(1'b0, 12'h004, 32'h0);
        chk(q, 32'h80);
        xfer(1'b1, 12'h004, 32'h20);
        chk(32'({run, sup}), 32'h2);
        xfer(1'b1, 12'h004, 32'h60);
        chk(32'({run, sup}), 32'h3);
        @(posedge ref_clk);
        standby_mode <= 1'b1;
        repeat (6) @(negedge ref_clk);
        chk(32'({run, sup}), 32'h2);
        xfer(1'b0, 12'h008, 32'h0);
        chk(q, 32'h6);
        @(posedge ref_clk);
        standby_mode <= 1'b0;
        repeat (6) @(negedge ref_clk);
        chk(32'({run, sup}), 32'h3);
        xfer(1'b0, 12'h008, 32'h0);
        chk(q, 32'h3);
        xfer(1'b1, 12'h004, 32'h40);
        chk(32'({run, sup, seg}), 32'h0);
        xfer(1'b0, 12'h000, 32'h0);
        chk(q, 32'h0F);
        xfer(1'b0, 12'h00C, 32'h0);
        chk(q, 32'h0);
        chk(32'(perr), 32'h1);
        xfer(1'b1, 12'h000, 32'hFF);
        xfer(1'b0, 12'h000, 32'h0);
        chk(q, 32'hEF);
    endtask : t_power
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // the whole run is near 140 cycles, so this only trips on a hang
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            wrap_up;
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset;
        t_codes;
        t_power;
        wrap_up;
    end
endmodule : lcd_segment_pin_and_power_control_tb
bind lsp_ctrl lsp_ctrl_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .standby_mode(standby_mode), .seg_drive_en(seg_drive_en),
    .port_enable(port_enable), .lcd_supply_on(lcd_supply_on), .lcd_run(lcd_run));
